// ### inc/imx_params.svh
// Offsets, field positions, reset values and gain codes of the input mixer registers.
// Assumes a 32-bit APB slave; printed offsets are register indices, byte address is four times.
`ifndef IMX_PARAMS_SVH
`define IMX_PARAMS_SVH

// Register indices as printed; the byte address is four times the index.
`define IMX_IDX_POWER      12'h002
`define IMX_IDX_BOOST      12'h015
`define IMX_IDX_LROUTE     12'h029
`define IMX_IDX_RROUTE     12'h02a
`define IMX_IDX_LBYPASS    12'h02b
`define IMX_IDX_RBYPASS    12'h02c
// Status register holding the decoded bypass gain steps and the two mixer enables.
`define IMX_IDX_STATUS     12'h030

// Power register fields.
`define IMX_BIT_LEFT_ENA   9
`define IMX_BIT_RIGHT_ENA  8
// Boost register fields.
`define IMX_BIT_RBOOST     8
`define IMX_BIT_LBOOST     7
// Route register fields.
`define IMX_BIT_AMP2_ON    8
`define IMX_BIT_AMP2_GAIN  7
`define IMX_BIT_AMP1_ON    5
`define IMX_BIT_AMP1_GAIN  4
`define IMX_LSB_RECORD     0
// Bypass register fields.
`define IMX_LSB_BYPASS     6
`define IMX_LSB_VOICE      0

// Writable bit masks of each register.
`define IMX_MASK_POWER     16'h0300
`define IMX_MASK_BOOST     16'h0180
`define IMX_MASK_ROUTE     16'h01b7
`define IMX_MASK_BYPASS    16'h01c7

// All fields reset to disabled or mute.
`define IMX_RESET_VALUE    16'h0000

// Three-bit gain codes.
`define IMX_CODE_MUTE      3'h0
`define IMX_CODE_TOP       3'h7
// Step index of the boosted top code: -12dB plus 9 steps of 3dB gives +15dB.
`define IMX_STEP_BOOST     4'h9

`endif

// ### inc/imx_pkg.sv
// Types shared by the input mixer register block.
// Assumes the parameter header is compiled alongside.
`default_nettype none

package imx_pkg;

  // Decoded controls of one three-bit gain path.
  typedef struct packed {
    logic       on;    // Path is unmuted.
    logic [3:0] step;  // Gain in 3dB steps above -12dB.
  } imx_gain_t;

  // Controls of one analogue input mixer.
  typedef struct packed {
    logic      enable;       // Mixer and voice path powered.
    logic      amp1_on;      // First amplifier path unmuted.
    logic      amp1_boost;   // First amplifier path at +30dB.
    logic      amp2_on;      // Second amplifier path unmuted.
    logic      amp2_boost;   // Second amplifier path at +30dB.
    imx_gain_t record_path;  // Loop-back from the output mixer.
    imx_gain_t bypass_path;  // Bypass-pin path.
    imx_gain_t voice_path;   // Differential voice path.
  } imx_mixer_t;

  // APB access phase state of the slave.
  typedef enum logic [0:0] {
    IMX_IDLE,
    IMX_ACCESS
  } imx_state_t;

endpackage : imx_pkg

`default_nettype wire

// ### rtl/imx_gain_decode.sv
// Decoder of one three-bit mute-and-gain field into an unmute flag and a step index.
// Assumes a registered code; the output is registered so it reaches the pins clean.
`default_nettype none
`include "imx_params.svh"

module imx_gain_decode
  import imx_pkg::*;
(
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Field code and boost option.
  input  wire logic [2:0] code,
  input  wire logic       boost,
  // Decoded controls.
  output imx_gain_t       gain
);

  // Decoded value before the register.
  imx_gain_t next_gain;

  // Code 000 mutes; codes 1..7 map to steps 0..6, the top code may jump to +15dB.
  assign next_gain.on   = (code != `IMX_CODE_MUTE);
  assign next_gain.step = (boost && code == `IMX_CODE_TOP) ? `IMX_STEP_BOOST :
                          (code == `IMX_CODE_MUTE) ? 4'h0 : {1'b0, code - 3'h1};

  // Output register, so the analogue side sees steady levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain <= '0;
    end else begin
      gain <= next_gain;
    end
  end

  // Top code under boost must give the +15dB step one cycle later.
  boost_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    (boost && code == `IMX_CODE_TOP) |=> gain.step == `IMX_STEP_BOOST)
    else $error("boosted top code not decoded to +15dB");

endmodule : imx_gain_decode

`default_nettype wire

// ### rtl/imx_regs.sv
// APB register bank for the two analogue input mixers of the codec.
// Assumes a single 100 MHz pclk and an APB master of the same clock domain.
//
// How it works
// - Power bit 9 enables left mixer, voice.
// - Power bit 8 enables right mixer, voice.
// - Boost bit 7 lifts left bypass top.
// - Left route bit 8 unmutes amplifier two.
// - Left route bit 7 gives amp two +30dB.
// - Left route bit 5 unmutes amplifier one.
// - Left route bit 4 gives amp one +30dB.
// - Left route bits 2:0 set record gain.
// - Left bypass bits 8:6 set bypass gain.
// - Boosted code 111 means +15dB, others unchanged.
// - Boost bit 8 lifts right bypass top.
// - Right route register mirrors the left one.
// - Right bypass bits 8:6, voice bits 2:0.
// - Left bypass bits 2:0 set voice gain.
`default_nettype none
`include "imx_params.svh"

module imx_regs
  import imx_pkg::*;
#(
  parameter int ADDR_W = 12  // APB byte address width.
)(
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Analogue mixer controls.
  output imx_mixer_t             left_input_mixer,
  output imx_mixer_t             right_input_mixer
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check.

  // The highest index times four must fit the address.
  if (ADDR_W < 8) begin : g_addr_check
    $error("imx_regs: ADDR_W too small for the register map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [15:0] mixer_power_enables;      // Mixer enables.
  logic [15:0] bypass_boost_control;     // Bypass boost options.
  logic [15:0] left_mixer_route_gain;    // Left amplifier and record paths.
  logic [15:0] right_mixer_route_gain;   // Right amplifier and record paths.
  logic [15:0] left_mixer_bypass_gain;   // Left bypass and voice paths.
  logic [15:0] right_mixer_bypass_gain;  // Right bypass and voice paths.
  imx_state_t  state;                    // APB phase tracker.
  logic [4:0]  left_ctl;                 // Left enable, amplifier mutes and gains, flopped.
  logic [4:0]  right_ctl;                // Right enable, amplifier mutes and gains, flopped.
  imx_gain_t   left_record;              // Decoded left record path.
  imx_gain_t   left_bypass;              // Decoded left bypass path.
  imx_gain_t   left_voice;               // Decoded left voice path.
  imx_gain_t   right_record;             // Decoded right record path.
  imx_gain_t   right_bypass;             // Decoded right bypass path.
  imx_gain_t   right_voice;              // Decoded right voice path.

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Map a byte address to a register index; unaligned addresses never match.
  function automatic logic [11:0] index_of(input logic [ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'(addr);
    index_of = (wide[1:0] == 2'b00) ? wide[13:2] : 12'hfff;
  endfunction : index_of

  // Merge write data into a register through its byte strobes and writable mask.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~lanes) | (data[15:0] & lanes);
  endfunction : merge

  wire logic [11:0] index      = index_of(paddr);
  wire logic        setup      = psel && !penable;
  wire logic        sel_power  = (index == `IMX_IDX_POWER);
  wire logic        sel_boost  = (index == `IMX_IDX_BOOST);
  wire logic        sel_lroute = (index == `IMX_IDX_LROUTE);
  wire logic        sel_rroute = (index == `IMX_IDX_RROUTE);
  wire logic        sel_lbyp   = (index == `IMX_IDX_LBYPASS);
  wire logic        sel_rbyp   = (index == `IMX_IDX_RBYPASS);
  wire logic        sel_status = (index == `IMX_IDX_STATUS);
  wire logic        mapped     = sel_power | sel_boost | sel_lroute | sel_rroute |
                                 sel_lbyp | sel_rbyp | sel_status;
  // Writes land at the edge that ends the access, where pready is sampled high.
  wire logic        wr_ok      = psel && penable && pready && pwrite && mapped && !sel_status;

  // Status shows the decoded step of both bypass paths and mixer enables.
  wire logic [15:0] status_word = {6'h00, left_input_mixer.enable, right_input_mixer.enable,
                                   left_input_mixer.bypass_path.step,
                                   right_input_mixer.bypass_path.step};

  // Read mux; unmapped addresses read zero.
  wire logic [15:0] read_word =
      sel_power  ? mixer_power_enables     :
      sel_boost  ? bypass_boost_control    :
      sel_lroute ? left_mixer_route_gain   :
      sel_rroute ? right_mixer_route_gain  :
      sel_lbyp   ? left_mixer_bypass_gain  :
      sel_rbyp   ? right_mixer_bypass_gain :
      sel_status ? status_word             : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait-free access; pready rises in the access cycle.

  // The slave answers every access in its first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= IMX_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      case (state)
        IMX_IDLE: begin
          // A setup cycle prepares the answer for the access cycle.
          if (setup) begin
            state   <= IMX_ACCESS;
            pready  <= 1'b1;
            // Unmapped addresses and writes to status are flagged as errors.
            pslverr <= !mapped || (pwrite && sel_status);
            prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, read_word};
          end
        end
        IMX_ACCESS: begin
          // Access completes at this edge; drop the answer.
          state   <= IMX_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          state  <= IMX_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; the new value is visible after the access edge.

  // Writes are committed at the access edge; a refused write changes nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mixer_power_enables     <= `IMX_RESET_VALUE;
      bypass_boost_control    <= `IMX_RESET_VALUE;
      left_mixer_route_gain   <= `IMX_RESET_VALUE;
      right_mixer_route_gain  <= `IMX_RESET_VALUE;
      left_mixer_bypass_gain  <= `IMX_RESET_VALUE;
      right_mixer_bypass_gain <= `IMX_RESET_VALUE;
    end else if (wr_ok) begin
      if (sel_power)
        mixer_power_enables <= merge(mixer_power_enables, pwdata, pstrb, `IMX_MASK_POWER);
      if (sel_boost)
        bypass_boost_control <= merge(bypass_boost_control, pwdata, pstrb, `IMX_MASK_BOOST);
      if (sel_lroute)
        left_mixer_route_gain <= merge(left_mixer_route_gain, pwdata, pstrb, `IMX_MASK_ROUTE);
      if (sel_rroute)
        right_mixer_route_gain <= merge(right_mixer_route_gain, pwdata, pstrb,
                                        `IMX_MASK_ROUTE);
      if (sel_lbyp)
        left_mixer_bypass_gain <= merge(left_mixer_bypass_gain, pwdata, pstrb,
                                        `IMX_MASK_BYPASS);
      if (sel_rbyp)
        right_mixer_bypass_gain <= merge(right_mixer_bypass_gain, pwdata, pstrb,
                                         `IMX_MASK_BYPASS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single-bit controls, registered toward the mixers.

  // Gain changes go straight through; pop avoidance is left to software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_ctl  <= 5'h00;
      right_ctl <= 5'h00;
    end else begin
      left_ctl  <= {mixer_power_enables[`IMX_BIT_LEFT_ENA],
                    left_mixer_route_gain[`IMX_BIT_AMP1_ON],
                    left_mixer_route_gain[`IMX_BIT_AMP1_GAIN],
                    left_mixer_route_gain[`IMX_BIT_AMP2_ON],
                    left_mixer_route_gain[`IMX_BIT_AMP2_GAIN]};
      right_ctl <= {mixer_power_enables[`IMX_BIT_RIGHT_ENA],
                    right_mixer_route_gain[`IMX_BIT_AMP1_ON],
                    right_mixer_route_gain[`IMX_BIT_AMP1_GAIN],
                    right_mixer_route_gain[`IMX_BIT_AMP2_ON],
                    right_mixer_route_gain[`IMX_BIT_AMP2_GAIN]};
    end
  end

  // The carriers only gather flop outputs, so each struct has a single driver.
  assign left_input_mixer  = {left_ctl, left_record, left_bypass, left_voice};
  assign right_input_mixer = {right_ctl, right_record, right_bypass, right_voice};

  ////////////////////////////////////////////////////////////////////////////
  // Three-bit gain decoders; each output is a register inside the decoder.

  // Left record loop-back gain.
  imx_gain_decode u_left_record (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (left_mixer_route_gain[`IMX_LSB_RECORD +: 3]),
    .boost   (1'b0),
    .gain    (left_record)
  );

  // Left bypass-pin gain with its boost option.
  imx_gain_decode u_left_bypass (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (left_mixer_bypass_gain[`IMX_LSB_BYPASS +: 3]),
    .boost   (bypass_boost_control[`IMX_BIT_LBOOST]),
    .gain    (left_bypass)
  );

  // Left differential voice gain.
  imx_gain_decode u_left_voice (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (left_mixer_bypass_gain[`IMX_LSB_VOICE +: 3]),
    .boost   (1'b0),
    .gain    (left_voice)
  );

  // Right record loop-back gain.
  imx_gain_decode u_right_record (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (right_mixer_route_gain[`IMX_LSB_RECORD +: 3]),
    .boost   (1'b0),
    .gain    (right_record)
  );

  // Right bypass-pin gain with its boost option.
  imx_gain_decode u_right_bypass (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (right_mixer_bypass_gain[`IMX_LSB_BYPASS +: 3]),
    .boost   (bypass_boost_control[`IMX_BIT_RBOOST]),
    .gain    (right_bypass)
  );

  // Right differential voice gain.
  imx_gain_decode u_right_voice (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (right_mixer_bypass_gain[`IMX_LSB_VOICE +: 3]),
    .boost   (1'b0),
    .gain    (right_voice)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // A setup cycle followed by its access cycle.
  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence apb_answer_s;
    pready && psel && penable;
  endsequence

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s |=> apb_answer_s or !psel)
    else $error("APB access not answered in its first access cycle");

  read_back_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_setup_s and !pwrite and sel_lroute) |=> prdata[15:0] == left_mixer_route_gain)
    else $error("left route register read back wrong");

  left_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 left_input_mixer.enable == $past(mixer_power_enables[`IMX_BIT_LEFT_ENA]))
    else $error("left mixer enable does not follow its bit");

  right_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 right_input_mixer.enable == $past(mixer_power_enables[`IMX_BIT_RIGHT_ENA]))
    else $error("right mixer enable does not follow its bit");

  amp2_left_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && sel_lroute && pstrb[1]) |=> ##1
      left_input_mixer.amp2_on == $past(pwdata[`IMX_BIT_AMP2_ON], 2))
    else $error("left amplifier two unmute wrong");

  amp1_gain_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && sel_lroute && pstrb[0]) |=> ##1
      left_input_mixer.amp1_boost == $past(pwdata[`IMX_BIT_AMP1_GAIN], 2))
    else $error("left amplifier one gain wrong");

  left_boost_a: assert property (@(posedge pclk) disable iff (!presetn)
    (bypass_boost_control[`IMX_BIT_LBOOST] &&
     left_mixer_bypass_gain[`IMX_LSB_BYPASS +: 3] == `IMX_CODE_TOP) [*2]
      |-> left_input_mixer.bypass_path.step == `IMX_STEP_BOOST)
    else $error("left bypass boost not applied");

  mute_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(left_mixer_bypass_gain[`IMX_LSB_BYPASS +: 3]) == `IMX_CODE_MUTE
      |-> !left_input_mixer.bypass_path.on)
    else $error("left bypass not muted by code 000");

  unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_setup_s and !mapped) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped address not refused");

  // Right boost mirrors the left one on its own bit.
  right_boost_a: assert property (@(posedge pclk) disable iff (!presetn)
    (bypass_boost_control[`IMX_BIT_RBOOST] &&
     right_mixer_bypass_gain[`IMX_LSB_BYPASS +: 3] == `IMX_CODE_TOP) [*2]
      |-> right_input_mixer.bypass_path.step == `IMX_STEP_BOOST)
    else $error("right bypass boost not applied");

  // Amplifier two gain level follows its route bit one edge later.
  amp2_boost_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 left_input_mixer.amp2_boost == $past(left_mixer_route_gain[`IMX_BIT_AMP2_GAIN]))
    else $error("left amplifier two gain does not follow its bit");

  // Amplifier one unmute follows its route bit one edge later.
  amp1_unmute_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 left_input_mixer.amp1_on == $past(left_mixer_route_gain[`IMX_BIT_AMP1_ON]))
    else $error("left amplifier one unmute does not follow its bit");

  // A record code of 000 must leave the loop-back path muted.
  record_mute_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(left_mixer_route_gain[`IMX_LSB_RECORD +: 3]) == `IMX_CODE_MUTE
      |-> !left_input_mixer.record_path.on)
    else $error("left record path not muted by code 000");

endmodule : imx_regs

`default_nettype wire

// ### verification/imx_regs_tb.sv
// Self-checking bench for the input mixer register block, driven over APB.
// Assumes the parameter header and the type package are compiled before it.
`default_nettype none
`include "imx_params.svh"

module testbench
  import imx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus, responses and bookkeeping.
  logic        pclk;               // Bus clock, 100 MHz.
  logic        presetn;            // Asynchronous reset, active low.
  logic        psel;               // APB select.
  logic        penable;            // APB access phase.
  logic        pwrite;             // APB direction.
  logic [11:0] paddr;              // APB byte address.
  logic [31:0] pwdata;             // APB write data.
  logic [3:0]  pstrb;              // APB byte strobes.
  logic [31:0] prdata;             // APB read data.
  logic        pready;             // APB ready.
  logic        pslverr;            // APB error.
  imx_mixer_t  left_input_mixer;   // Left mixer controls.
  imx_mixer_t  right_input_mixer;  // Right mixer controls.
  int          err_count;          // Mismatches seen.
  int          num_checks;         // Comparisons made.
  logic [15:0] sh [0:5];           // Shadow of what each register should hold.
  logic [31:0] rd;                 // Read data of the last transfer.
  logic        er;                 // Error flag of the last transfer.
  // Byte addresses and writable masks, in the order of the shadow.
  localparam logic [11:0] AD [0:5] = '{12'(`IMX_IDX_POWER << 2), 12'(`IMX_IDX_BOOST << 2),
    12'(`IMX_IDX_LROUTE << 2), 12'(`IMX_IDX_RROUTE << 2), 12'(`IMX_IDX_LBYPASS << 2),
    12'(`IMX_IDX_RBYPASS << 2)};
  localparam logic [15:0] MK [0:5] = '{`IMX_MASK_POWER, `IMX_MASK_BOOST, `IMX_MASK_ROUTE,
    `IMX_MASK_ROUTE, `IMX_MASK_BYPASS, `IMX_MASK_BYPASS};
  localparam logic [11:0] STAT = 12'(`IMX_IDX_STATUS << 2);

  imx_regs #(.ADDR_W(12)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .left_input_mixer(left_input_mixer),
    .right_input_mixer(right_input_mixer));

  // Free-running clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reporting and comparison.
  task automatic fail(input string m);
    err_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail(m);
    end
  endtask : cmp32

  task automatic cmpmix(input imx_mixer_t got, input imx_mixer_t exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail(m);
    end
  endtask : cmpmix

  task automatic conclude;
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Expected decode of a three-bit field: mute, one step per 3dB, boosted top at +15dB.
  function automatic imx_gain_t gdec(input logic [2:0] c, input logic b);
    gdec.on = (c != 3'h0);
    gdec.step = (c == 3'h0) ? 4'h0 : (b && c == 3'h7) ? 4'h9 : {1'b0, c} - 4'h1;
  endfunction : gdec

  function automatic imx_mixer_t emix(input logic en, input logic b, input logic [15:0] r,
                                      input logic [15:0] p);
    emix.enable = en;
    emix.amp1_on = r[5];
    emix.amp1_boost = r[4];
    emix.amp2_on = r[8];
    emix.amp2_boost = r[7];
    emix.record_path = gdec(r[2:0], 1'b0);
    emix.bypass_path = gdec(p[8:6], b);
    emix.voice_path = gdec(p[2:0], 1'b0);
  endfunction : emix

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master: the request is held until pready is sampled high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'hffff, d};  // Upper lanes carry ones, which must be ignored.
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends once pready is seen high; only a slave that never answers is left to the watchdog.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never assigns psel in this same time step.
    @(posedge pclk);
  endtask : apb

  // Write a register and keep the shadow in step, honouring mask and strobes.
  task automatic wr(input int i, input logic [15:0] v, input logic [3:0] s);
    logic [15:0] m;
    m = MK[i] & {{8{s[1]}}, {8{s[0]}}};
    sh[i] = (sh[i] & ~m) | (v & m);
    apb(1'b1, AD[i], v, s);
    cmp32({31'h0, er}, 32'h0, "write flagged as error");
  endtask : wr

  task automatic rd_chk(input int i);
    apb(1'b0, AD[i], 16'h0000, 4'h0);
    cmp32(rd, {16'h0000, sh[i]}, "read back");
    cmp32({31'h0, er}, 32'h0, "read flagged as error");
  endtask : rd_chk

  // Outputs settle one edge after the write edge; two more edges cover that.
  task automatic check_mix;
    repeat (2) @(posedge pclk);
    cmpmix(left_input_mixer, emix(sh[0][9], sh[1][7], sh[2], sh[4]), "left mixer");
    cmpmix(right_input_mixer, emix(sh[0][8], sh[1][8], sh[3], sh[5]), "right mixer");
  endtask : check_mix

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rd_chk(i);
    end
    check_mix();
  endtask : t_reset

  // Each enable alone, then a write with the upper byte lane switched off.
  task automatic t_power;
    wr(0, 16'h0200, 4'hf);
    check_mix();
    wr(0, 16'h0100, 4'hf);
    check_mix();
    wr(0, 16'hffff, 4'h1);
    check_mix();
    rd_chk(0);
    wr(0, 16'h0300, 4'hf);
    apb(1'b0, STAT, 16'h0000, 4'h0);
    cmp32(rd, 32'h0000_0300, "status enables");
    // Both mixers go quiet again, so later gain changes never touch a live path.
    wr(0, 16'h0000, 4'hf);
  endtask : t_power

  // Every record code, with the mute and gain bits walked alongside; reserved bits set on the left route only.
  task automatic t_route;
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {7'h00, i[0], i[1], 1'b0, i[2], i[0] ^ i[1], 1'b0, i[2:0]};
      wr(2, v | 16'hfe48, 4'hf);
      wr(3, v ^ 16'h01b7, 4'hf);
      check_mix();
      rd_chk(2);
      rd_chk(3);
    end
  endtask : t_route

  // Every bypass and voice code under each combination of the two boost bits.
  task automatic t_bypass;
    logic [31:0] st;
    imx_gain_t   gl;
    imx_gain_t   gr;
    for (int b = 0; b < 4; b++) begin
      // Reference and bias enables sit outside this block and are taken as already set.
      wr(1, {7'h00, b[1:0], 7'h00}, 4'hf);
      for (int c = 0; c < 8; c++) begin
        wr(4, {7'h00, c[2:0], 3'h0, ~c[2:0]}, 4'hf);
        wr(5, {7'h00, c[2:0], 3'h7, c[2:0]}, 4'hf);
        check_mix();
        gl = gdec(c[2:0], b[0]);
        gr = gdec(c[2:0], b[1]);
        st = {22'h0, sh[0][9:8], gl.step, gr.step};
        apb(1'b0, STAT, 16'h0000, 4'h0);
        cmp32(rd, st, "status");
      end
      rd_chk(1);
    end
  endtask : t_bypass

  // Unmapped, unaligned and read-only places answer with an error and change nothing.
  task automatic t_errors;
    apb(1'b0, 12'h0fc, 16'h0000, 4'h0);
    cmp32({31'h0, er}, 32'h1, "unmapped read error");
    cmp32(rd, 32'h0, "unmapped read data");
    apb(1'b1, STAT, 16'hffff, 4'hf);
    cmp32({31'h0, er}, 32'h1, "status write error");
    apb(1'b1, AD[2] + 12'h001, 16'h01b7, 4'hf);
    cmp32({31'h0, er}, 32'h1, "unaligned write error");
    check_mix();
    rd_chk(2);
  endtask : t_errors

  // A reset in mid-run returns every field to disabled or mute.
  task automatic t_reset_mid;
    presetn <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      sh[i] = 16'h0000;
    end
    check_mix();
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(2);
  endtask : t_reset_mid

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    err_count = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    for (int i = 0; i < 6; i++) begin
      sh[i] = 16'h0000;
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_power();
    t_route();
    t_bypass();
    t_errors();
    t_reset_mid();
    conclude();
  end

  // Watchdog: the whole run needs under six hundred cycles, so this is ample.
  initial begin
    #200us;
    err_count++;
    conclude();
  end

endmodule : testbench

`default_nettype wire
